// ---- resettable_async_sram_8kx8_tb_top.sv ----
// Purpose: self-checking bench for the memory host controller
// Assumes: behavioural memory on the far side
// Notes:   expected read data queued at request time
`timescale 1ns/1ps
module resettable_async_sram_8kx8_tb_top
	import sram_host_pkg::*;
;
	logic sys_clk, reset_n, req_valid, req_ready, rdata_valid, retained;
	logic data_oe, mem_en;
	req_t req;
	pins_t pins;
	logic [DATA_W-1:0] rdata, data_out, mem_out, bus, float_q, d, e;
	logic [ADDR_W-1:0] a;
	logic [DATA_W-1:0] mirror [0:8191];
	logic [DATA_W-1:0] exp_q [$];
	int bad_count, cmp_count;
	// undriven wire changes every cycle
	assign bus = data_oe ? data_out : (mem_en ? mem_out : float_q);
	sram_host_ctrl u_sram_host_ctrl (.sys_clk, .reset_n, .req, .req_valid,
		.req_ready, .rdata, .rdata_valid, .retained, .pins,
		.data_in(bus), .data_out, .data_oe);
	sram_device_model u_sram_device_model (.pins, .bus, .mem_out, .mem_en);
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) float_q <= float_q + 8'h5b;
	task automatic check(string n, logic [7:0] x, logic [7:0] s);
		cmp_count++;
		if (x !== s) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask : check
	always @(negedge sys_clk) if (rdata_valid === 1'b1) begin
		e = exp_q.size() ? exp_q.pop_front() : ~rdata;
		check("rdata", e, rdata);
	end
	task automatic do_req(cmd_t c, logic [12:0] ad, logic [7:0] wd);
		int n;
		n = 0;
		@(negedge sys_clk);
		// raise valid only once ready stands, so the next edge takes it
		while (req_ready !== 1'b1 && n < 200) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 200) check("req_ready", 8'h01, 8'h00);
		req <= '{cmd: c, addr: ad, wdata: wd};
		req_valid <= 1'b1;
		@(negedge sys_clk);
		req_valid <= 1'b0;
	endtask : do_req
	task automatic wr(logic [12:0] ad, logic [7:0] wd);
		mirror[ad] = wd;
		do_req(CMD_WRITE, ad, wd);
	endtask : wr
	task automatic rd(logic [12:0] ad);
		exp_q.push_back(mirror[ad]);
		do_req(CMD_READ, ad, 8'h00);
	endtask : rd
	task automatic clr;
		do_req(CMD_CLEAR, 13'h0000, 8'h00);
		foreach (mirror[i]) mirror[i] = 8'h00;
	endtask : clr
	task automatic wait_ret(logic v);
		int n;
		for (n = 0; n < 30 && retained !== v; n++) @(negedge sys_clk);
		check("retained", {7'h00, v}, {7'h00, retained});
	endtask : wait_ret
	task automatic tally_and_finish;
		$display("counts: %0d compared, %0d mismatched", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	// whole run is under a thousand cycles
	initial begin
		#60000;
		bad_count++;
		tally_and_finish;
	end
	initial begin
		req = '0;
		req_valid = 1'b0;
		reset_n = 1'b0;
		float_q = 8'h00;
		bad_count = 0;
		cmp_count = 0;
		void'($urandom(32'h2dcf));
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk) reset_n = 1'b1;
		clr();
		rd(13'h1fff);
		$display("test clear done");
		wr(13'h0000, 8'ha5);
		wr(13'h1fff, 8'h5a);
		wr(13'h1fff, 8'h3c);
		rd(13'h0000);
		rd(13'h1fff);
		$display("test edges done");
		repeat (40) begin
			a = 13'($urandom);
			d = 8'($urandom);
			if ($urandom % 2) wr(a, d);
			else rd(a);
		end
		$display("test random done");
		clr();
		rd(a);
		wr(a, 8'h96);
		do_req(CMD_RETAIN_ENTER, 13'h0000, 8'h00);
		wait_ret(1'b1);
		@(negedge sys_clk);
		req <= '{cmd: CMD_READ, addr: a, wdata: 8'h00};
		req_valid <= 1'b1;
		repeat (20) @(negedge sys_clk);
		req_valid <= 1'b0;
		do_req(CMD_RETAIN_EXIT, 13'h0000, 8'h00);
		wait_ret(1'b0);
		rd(a);
		$display("test retention done");
		repeat (100) if (exp_q.size() != 0) @(posedge sys_clk);
		check("pending reads", 8'h00, 8'(exp_q.size()));
		tally_and_finish;
	end
endmodule : resettable_async_sram_8kx8_tb_top

// ---- sram_device_model.sv ----
// Purpose: behavioural 8K x 8 memory with clear input
// Assumes: pins come from the host, bus is the resolved data wire
// Notes:   clockless, levels only
`timescale 1ns/1ps
module sram_device_model
	import sram_host_pkg::*;
(
	input wire pins_t             pins,
	input wire logic [DATA_W-1:0] bus,
	output logic [DATA_W-1:0]     mem_out,
	output logic                  mem_en
);
	logic [DATA_W-1:0] mem [0:8191];
	logic              sel;
	assign sel = !pins.select_low_active_n && pins.select_high_active;
	always @* if (!pins.clear_n) foreach (mem[i]) mem[i] = '0;
	// transparent during overlap, so first closing edge ends it
	always @* if (sel && !pins.write_n && pins.clear_n)
		mem[pins.word_address] = bus;
	// floats in standby and during writes
	assign mem_en = sel && pins.write_n && !pins.out_en_n && pins.clear_n;
	assign mem_out = mem[pins.word_address];
endmodule : sram_device_model

// ---- sram_host_ctrl.sv ----
// Purpose: host side controller for an 8K x 8 asynchronous static memory
// Assumes: memory pins are driven only from this module's flip-flops
// Notes:   one request at a time, accepted when req_ready is high
// What this block does
// - the memory is selected only with low select low and high select high.
// - the host keeps write strobe high whenever the address changes.
// - the host never drives the data lines while the memory may drive them.
// - the host holds the write strobe high for a whole read.
// - before retention the host deselects by high select and holds clear high, and waits a read cycle after supply returns.
`timescale 1ns/1ps
module sram_host_ctrl
	import sram_host_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	input  wire req_t              req,
	input  wire logic              req_valid,
	output logic                   req_ready,
	output logic [DATA_W-1:0]      rdata,
	output logic                   rdata_valid,
	output logic                   retained,
	output pins_t                  pins,
	input  wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0]      data_out,
	output logic                   data_oe
);

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_RD_SETUP,
		ST_RD_ACCESS,
		ST_WR_SETUP,
		ST_WR_PULSE,
		ST_WR_RECOVER,
		ST_CLR_PULSE,
		ST_RETAIN,
		ST_RESUME
	} state_t;

	state_t            state_q;
	logic              tmr_load;
	logic [CNT_W-1:0]  tmr_val;
	logic              tmr_done;
	logic [DATA_W-1:0] rd_sync1_q;
	logic [DATA_W-1:0] rd_sync2_q;

	sram_phase_timer u_timer (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.load     (tmr_load),
		.load_val (tmr_val),
		.done     (tmr_done)
	);

	// data lines come from outside the clock domain
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_sync1_q <= 8'h00;
			rd_sync2_q <= 8'h00;
		end else begin
			rd_sync1_q <= data_in;
			rd_sync2_q <= rd_sync1_q;
		end
	end

	// timer load on every phase entry
	always_comb begin
		tmr_load = 1'b0;
		tmr_val  = 8'h00;
		unique case (state_q)
			ST_IDLE: begin
				// same take condition as the pin and data processes
				if (req_valid && req_ready) begin
					tmr_load = 1'b1;
					unique case (req.cmd)
						CMD_CLEAR:        tmr_val = CNT_W'(CLEAR_PULSE_CYC);
						CMD_RETAIN_ENTER: tmr_val = CNT_W'(DESEL_RET_CYC);
						default:          tmr_val = CNT_W'(ADDR_SETUP_CYC);
					endcase
				end
			end
			ST_RD_SETUP: begin
				tmr_load = tmr_done;
				tmr_val  = CNT_W'(READ_CYCLE_CYC + 2);
			end
			ST_WR_SETUP: begin
				tmr_load = tmr_done;
				tmr_val  = CNT_W'(WRITE_PULSE_CYC);
			end
			ST_WR_PULSE: begin
				tmr_load = tmr_done;
				tmr_val  = CNT_W'(WRITE_REC_CYC);
			end
			ST_RETAIN: begin
				tmr_load = req_valid && req_ready &&
					req.cmd == CMD_RETAIN_EXIT;
				tmr_val  = CNT_W'(READ_CYCLE_CYC);
			end
			default: begin
				tmr_load = 1'b0;
			end
		endcase
	end

	// sequencer
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (req_valid && req_ready) begin
						unique case (req.cmd)
							CMD_READ:         state_q <= ST_RD_SETUP;
							CMD_WRITE:        state_q <= ST_WR_SETUP;
							CMD_CLEAR:        state_q <= ST_CLR_PULSE;
							CMD_RETAIN_ENTER: state_q <= ST_RETAIN;
							default:          state_q <= ST_IDLE;
						endcase
					end
				end
				ST_RD_SETUP:   if (tmr_done) state_q <= ST_RD_ACCESS;
				ST_RD_ACCESS:  if (tmr_done) state_q <= ST_IDLE;
				ST_WR_SETUP:   if (tmr_done) state_q <= ST_WR_PULSE;
				ST_WR_PULSE:   if (tmr_done) state_q <= ST_WR_RECOVER;
				ST_WR_RECOVER: if (tmr_done) state_q <= ST_IDLE;
				ST_CLR_PULSE:  if (tmr_done) state_q <= ST_IDLE;
				ST_RETAIN: begin
					if (req_valid && req_ready &&
						req.cmd == CMD_RETAIN_EXIT) begin
						state_q <= ST_RESUME;
					end
				end
				ST_RESUME:     if (tmr_done) state_q <= ST_IDLE;
				default:       state_q <= ST_IDLE;
			endcase
		end
	end

	// request handshake
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			req_ready <= 1'b0;
		end else begin
			req_ready <= (state_q == ST_IDLE && !req_valid) ||
				(state_q == ST_RETAIN && !req_valid);
		end
	end

	// memory pins
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pins <= PINS_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					pins.write_n  <= 1'b1;
					pins.out_en_n <= 1'b1;
					pins.clear_n  <= 1'b1;
					if (req_valid && req_ready) begin
						// address moves only with strobe high
						pins.word_address <= req.addr;
						unique case (req.cmd)
							CMD_READ, CMD_WRITE: begin
								pins.select_low_active_n <= 1'b0;
								pins.select_high_active  <= 1'b1;
							end
							CMD_CLEAR: begin
								pins.clear_n <= 1'b0;
							end
							CMD_RETAIN_ENTER: begin
								// power down via high select
								pins.select_high_active  <= 1'b0;
								pins.select_low_active_n <= 1'b1;
							end
							default: begin
								pins.clear_n <= 1'b1;
							end
						endcase
					end
				end
				ST_RD_SETUP: begin
					pins.write_n  <= 1'b1;
					pins.out_en_n <= 1'b0;
				end
				ST_RD_ACCESS: begin
					if (tmr_done) begin
						pins.out_en_n            <= 1'b1;
						pins.select_low_active_n <= 1'b1;
						pins.select_high_active  <= 1'b0;
					end
				end
				ST_WR_SETUP: begin
					pins.out_en_n <= 1'b1;
					if (tmr_done) begin
						pins.write_n <= 1'b0;
					end
				end
				ST_WR_PULSE: begin
					if (tmr_done) begin
						pins.write_n <= 1'b1;
					end
				end
				ST_WR_RECOVER: begin
					if (tmr_done) begin
						pins.select_low_active_n <= 1'b1;
						pins.select_high_active  <= 1'b0;
					end
				end
				ST_CLR_PULSE: begin
					if (tmr_done) begin
						pins.clear_n <= 1'b1;
					end
				end
				ST_RETAIN: begin
					pins.clear_n            <= 1'b1;
					pins.select_high_active <= 1'b0;
				end
				ST_RESUME: begin
					pins.clear_n <= 1'b1;
				end
				default: begin
					pins <= PINS_IDLE;
				end
			endcase
		end
	end

	// data drive only in write phases, never with output enable low
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			data_out <= 8'h00;
			data_oe  <= 1'b0;
		end else begin
			if (state_q == ST_IDLE && req_valid && req_ready &&
				req.cmd == CMD_WRITE) begin
				data_out <= req.wdata;
				data_oe  <= 1'b1;
			end else if (state_q == ST_WR_RECOVER && tmr_done) begin
				data_oe <= 1'b0;
			end else if (state_q != ST_WR_SETUP && state_q != ST_WR_PULSE &&
				state_q != ST_WR_RECOVER) begin
				data_oe <= 1'b0;
			end
		end
	end

	// read capture at end of access window
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata       <= 8'h00;
			rdata_valid <= 1'b0;
		end else begin
			rdata_valid <= 1'b0;
			if (state_q == ST_RD_ACCESS && tmr_done) begin
				rdata       <= rd_sync2_q;
				rdata_valid <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			retained <= 1'b0;
		end else begin
			retained <= (state_q == ST_RETAIN);
		end
	end

endmodule : sram_host_ctrl

// ---- sram_host_ctrl_sva.sv ----
// Purpose: pin protocol checks on the memory host controller
// Assumes: sees only controller ports, one clock domain
// Notes:   pulse counts follow the package timing figures
`timescale 1ns/1ps
module sram_host_ctrl_chk
	import sram_host_pkg::*;
(
	input wire logic  sys_clk,
	input wire logic  reset_n,
	input wire logic  rdata_valid,
	input wire logic  retained,
	input wire pins_t pins,
	input wire logic  data_oe
);
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	logic sel;
	assign sel = !pins.select_low_active_n && pins.select_high_active;
	sequence wr_low_s; (!pins.write_n)[*8]; endsequence
	sequence clr_low_s; (!pins.clear_n)[*8] ##1 (!pins.clear_n)[*3]; endsequence
	a_addr_hold: assert property ($changed(pins.word_address) |-> pins.write_n && $past(pins.write_n))
		else $error("address moved with write strobe low");
	a_write_pulse: assert property ($fell(pins.write_n) |-> wr_low_s ##1 pins.write_n)
		else $error("write pulse length wrong");
	a_write_sel: assert property (!pins.write_n |-> sel && data_oe)
		else $error("write strobe without full select");
	a_write_end: assert property ($rose(pins.write_n) |-> sel ##[1:2] !pins.select_high_active)
		else $error("write not closed by deselect");
	a_read_strobe: assert property (!pins.out_en_n |-> pins.write_n)
		else $error("write strobe low during read");
	a_no_clash: assert property (data_oe |-> !(sel && pins.write_n && !pins.out_en_n))
		else $error("host drives while memory drives");
	a_clear_len: assert property ($fell(pins.clear_n) |-> clr_low_s ##1 pins.clear_n)
		else $error("clear pulse length wrong");
	a_clear_quiet: assert property (!pins.clear_n |-> !sel && pins.write_n)
		else $error("memory accessed during clear");
	a_retain_pins: assert property (retained |-> !pins.select_high_active && pins.clear_n)
		else $error("retention without power-down pins");
	a_valid_pulse: assert property (rdata_valid |=> !rdata_valid)
		else $error("read valid longer than one cycle");
endmodule : sram_host_ctrl_chk

bind sram_host_ctrl sram_host_ctrl_chk u_chk (.sys_clk, .reset_n, .rdata_valid,
	.retained, .pins, .data_oe);

// ---- sram_host_pkg.sv ----
// Purpose: shared constants and types for the static memory host controller
// Assumes: 250 MHz sys_clk, 8K x 8 asynchronous memory with clear input
// Notes:   pin timings are whole cycles derived from nanosecond figures
package sram_host_pkg;

	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;

	localparam int CLK_PERIOD_PS = 4000;

	// pin timing figures in ns, counts derived below
	localparam int ADDR_SETUP_NS       = 4;
	localparam int WRITE_PULSE_NS      = 25;
	localparam int WRITE_RECOVERY_NS   = 4;
	localparam int READ_CYCLE_NS       = 30;
	localparam int CLEAR_PULSE_NS      = 40;
	localparam int DESEL_TO_RET_NS     = 0;

	function automatic int cyc_up(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_up

	localparam int ADDR_SETUP_CYC  = cyc_up(ADDR_SETUP_NS);
	localparam int WRITE_PULSE_CYC = cyc_up(WRITE_PULSE_NS);
	localparam int WRITE_REC_CYC   = cyc_up(WRITE_RECOVERY_NS);
	localparam int READ_CYCLE_CYC  = cyc_up(READ_CYCLE_NS);
	localparam int CLEAR_PULSE_CYC = cyc_up(CLEAR_PULSE_NS);
	localparam int DESEL_RET_CYC   = cyc_up(DESEL_TO_RET_NS);

	localparam int CNT_W = 8;

	typedef enum logic [2:0] {
		CMD_READ,
		CMD_WRITE,
		CMD_CLEAR,
		CMD_RETAIN_ENTER,
		CMD_RETAIN_EXIT
	} cmd_t;

	typedef struct packed {
		cmd_t              cmd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} req_t;

	typedef struct packed {
		logic              select_low_active_n;
		logic              select_high_active;
		logic              write_n;
		logic              out_en_n;
		logic              clear_n;
		logic [ADDR_W-1:0] word_address;
	} pins_t;

	localparam pins_t PINS_IDLE = '{
		select_low_active_n: 1'b1,
		select_high_active:  1'b0,
		write_n:             1'b1,
		out_en_n:            1'b1,
		clear_n:             1'b1,
		word_address:        13'h0000
	};

endpackage : sram_host_pkg

// ---- sram_phase_timer.sv ----
// Purpose: down counter that times each bus phase
// Assumes: load and count on the same clock
// Notes:   done is high while the count is zero
`timescale 1ns/1ps
module sram_phase_timer
	import sram_host_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] load_val,
	output logic                  done
);

	logic [CNT_W-1:0] cnt_q;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 8'h00;
		end else if (load) begin
			cnt_q <= load_val;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end

	assign done = (cnt_q == 8'h00);

endmodule : sram_phase_timer
